// [hw/cbi_consts.svh]
`ifndef CBI_CONSTS_SVH
`define CBI_CONSTS_SVH

// =====================================================================
// Bus geometry
`define CBI_ADDR_W 23
`define CBI_DATA_W 16
`define CBI_BYTE_W 8
`define CBI_LEVEL_W 3
`define CBI_SYNC_W 25

// =====================================================================
// Fixed patterns
`define CBI_IACK_HIGH_ONES 20'hF_FFFF
`define CBI_ADDR_ZERO 23'h00_0000
`define CBI_DATA_ZERO 16'h0000
`define CBI_LEVEL_NONE 3'h0

// =====================================================================
// Timing: clock period and reset-instruction pulse, both in ns
`define CBI_CLK_PERIOD_NS 32'h0000_0032
`define CBI_RESET_OUT_NS 32'h0000_1838
`define CBI_RESET_OUT_CYC ((`CBI_RESET_OUT_NS + `CBI_CLK_PERIOD_NS - 32'h0000_0001) / `CBI_CLK_PERIOD_NS)
`define CBI_CNT_W 8
`define CBI_CNT_ZERO 8'h00
`define CBI_CNT_ONE 8'h01
// Reset-out tail in cycles, covering the input synchroniser so our own pulse never reads as external
`define CBI_SYNC_LAT 8'h04

`endif

// [hw/cbi_pkg.sv]
package cbi_pkg;

  // =====================================================================
  // Request from the processor core
  typedef struct packed {
    logic iack;
    logic rd;
    logic upper;
    logic lower;
    logic [22:0] addr;
    logic [2:0] level;
    logic [15:0] wdata;
  } cbi_req_t;

  // =====================================================================
  // Registered pin drive of the transfer group
  typedef struct packed {
    logic [22:0] addr;
    logic addrOe;
    logic [15:0] dataOut;
    logic dataOe;
    logic addrValidStrobeN;
    logic readNotWrite;
    logic upperByteStrobeN;
    logic lowerByteStrobeN;
    logic ctrlOe;
  } cbi_pins_t;

  typedef enum logic [2:0] {
    stIdle,
    stAddr,
    stStrobe,
    stAckWait,
    stLatch,
    stClose,
    stRetry
  } cbi_state_t;

endpackage : cbi_pkg

// [hw/cbi_sync.sv]
`timescale 1ns/1ps
`include "cbi_consts.svh"

// Three-stage input synchroniser; output follows once stages two and three agree
module cbi_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '1
) (
  // Clock and control
  input logic clk_sys,
  input logic rst,
  input logic ce,
  // Data
  input logic [W-1:0] din,
  output logic [W-1:0] dout
);

  generate
    if (W < 1)
    begin : g_chk
      $error("cbi_sync: width must be at least one");
    end
  endgenerate

  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      logic s1_q, s2_q, s3_q, out_q;
      logic s1_d, s2_d, s3_d, out_d;
      always_comb
      begin
        s1_d = s1_q;
        s2_d = s2_q;
        s3_d = s3_q;
        out_d = out_q;
        if (ce)
        begin
          s1_d = din[i];
          s2_d = s1_q;
          s3_d = s2_q;
          // First stage feeds only the second; decision made on stages two and three
          if (s2_q == s3_q)
            out_d = s3_q;
        end
      end
      always_ff @(posedge clk_sys)
      begin
        if (rst)
        begin
          s1_q <= RST_VAL[i];
          s2_q <= RST_VAL[i];
          s3_q <= RST_VAL[i];
          out_q <= RST_VAL[i];
        end
        else
        begin
          s1_q <= s1_d;
          s2_q <= s2_d;
          s3_q <= s3_d;
          out_q <= out_d;
        end
      end
      assign dout[i] = out_q;
    end
  endgenerate

endmodule : cbi_sync

// [hw/cbi_arbiter.sv]
`timescale 1ns/1ps

// Three-wire mastership arbitration, processor side
module cbi_arbiter (
  // Clock and control
  input logic clk_sys,
  input logic rst,
  input logic ce,
  // Synchronised pins
  input logic mastershipRequestN,
  input logic mastershipTakenN,
  // Transfer engine state
  input logic cycleActive,
  // Results
  output logic mastershipGrantN,
  output logic ownBus
);

  logic grant_q, grant_d;
  logic released_q, released_d;

  always_comb
  begin
    grant_d = grant_q;
    released_d = released_q;
    if (ce)
    begin
      // Grant announces release at the end of the running cycle
      if (!mastershipTakenN)
      begin
        grant_d = 1'b0;
        released_d = 1'b1;
      end
      else if (!mastershipRequestN)
      begin
        grant_d = 1'b1;
        // Bus is handed over only once no cycle of ours is running
        released_d = released_q | ~cycleActive;
      end
      else
      begin
        grant_d = 1'b0;
        released_d = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      grant_q <= 1'b0;
      released_q <= 1'b0;
    end
    else
    begin
      grant_q <= grant_d;
      released_q <= released_d;
    end
  end

  assign mastershipGrantN = ~grant_q;
  assign ownBus = ~released_q & ~grant_q;

endmodule : cbi_arbiter

// [hw/cbi_bus_ctrl.sv]
`timescale 1ns/1ps
`include "cbi_consts.svh"

module cbi_bus_ctrl #(
  parameter int ADDR_W = `CBI_ADDR_W,
  parameter int DATA_W = `CBI_DATA_W
) (
  // Clock and control
  input logic clk_sys,
  input logic rst,
  input logic ce,
  // Core request and answer
  input logic reqValid,
  output logic reqReady,
  input cbi_pkg::cbi_req_t req,
  output logic respDone,
  output logic respFault,
  output logic [DATA_W-1:0] respData,
  // Core system control
  input logic resetInstr,
  input logic coreStopped,
  output logic coreInit,
  output logic extHalted,
  output logic [2:0] interruptLevel,
  // Transfer pins
  output cbi_pkg::cbi_pins_t busPins,
  input logic [DATA_W-1:0] dataIn,
  input logic transferAcknowledgeN,
  input logic busFaultInputN,
  // Arbitration pins
  input logic mastershipRequestN,
  output logic mastershipGrantN,
  input logic mastershipTakenN,
  // Interrupt pins
  input logic interruptLevelBitLowN,
  input logic interruptLevelBitMidN,
  input logic interruptLevelBitHighN,
  // Open-drain reset and halt
  input logic resetPinIn,
  output logic resetPinOut,
  output logic resetPinOe,
  input logic haltPinIn,
  output logic haltPinOut,
  output logic haltPinOe
);

  // =====================================================================
  // Elaboration checks
  generate
    if (ADDR_W != `CBI_ADDR_W || DATA_W != `CBI_DATA_W)
    begin : g_chk
      $error("cbi_bus_ctrl: bus widths are fixed by the pin-out");
    end
  endgenerate

  localparam logic [`CBI_CNT_W-1:0] RESET_OUT_CYC = `CBI_CNT_W'(`CBI_RESET_OUT_CYC);

  // =====================================================================
  // Input synchronisers
  logic [`CBI_SYNC_W-1:0] syncIn, syncOut;
  logic [DATA_W-1:0] dataSync;
  logic ackSyncN, faultSyncN, reqSyncN, takenSyncN, resetSyncN, haltSyncN;
  logic [2:0] iplSyncN;

  assign syncIn = {dataIn, transferAcknowledgeN, busFaultInputN, mastershipRequestN,
                   mastershipTakenN, resetPinIn, haltPinIn,
                   interruptLevelBitHighN, interruptLevelBitMidN, interruptLevelBitLowN};

  cbi_sync #(
    .W(`CBI_SYNC_W),
    .RST_VAL({`CBI_SYNC_W{1'b1}})
  ) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .din(syncIn),
    .dout(syncOut)
  );

  assign {dataSync, ackSyncN, faultSyncN, reqSyncN, takenSyncN, resetSyncN, haltSyncN, iplSyncN} = syncOut;

  // =====================================================================
  // Arbitration
  logic cycleActive, ownBus;

  cbi_arbiter u_arb (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .mastershipRequestN(reqSyncN),
    .mastershipTakenN(takenSyncN),
    .cycleActive(cycleActive),
    .mastershipGrantN(mastershipGrantN),
    .ownBus(ownBus)
  );

  // =====================================================================
  // Helpers
  function automatic logic [DATA_W-1:0] laneData(input cbi_pkg::cbi_req_t r);
    logic [`CBI_BYTE_W-1:0] hiByte, loByte;
    hiByte = r.wdata[DATA_W-1:`CBI_BYTE_W];
    loByte = r.wdata[`CBI_BYTE_W-1:0];
    if (r.upper && !r.lower)
      laneData = {hiByte, hiByte};
    else if (r.lower && !r.upper)
      laneData = {loByte, loByte};
    else
      laneData = r.wdata;
  endfunction : laneData

  function automatic logic [ADDR_W-1:0] cycleAddr(input cbi_pkg::cbi_req_t r);
    if (r.iack)
      cycleAddr = {`CBI_IACK_HIGH_ONES, r.level};
    else
      cycleAddr = r.addr;
  endfunction : cycleAddr

  // =====================================================================
  // Transfer engine state
  cbi_pkg::cbi_state_t state_q, state_d;
  cbi_pkg::cbi_req_t req_q, req_d;
  cbi_pkg::cbi_pins_t pins_q, pins_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic done_q, done_d;
  logic fault_q, fault_d;
  logic [`CBI_CNT_W-1:0] rstCnt_q, rstCnt_d;
  logic [2:0] level_q, level_d;
  logic init_q, init_d;
  logic haltDrive_q, haltDrive_d;
  logic extHalt;
  logic canStart;

  // Own halt drive is excluded while held; after release the synchroniser still shows the pin low as external halt for four cycles
  assign extHalt = ~haltSyncN & ~haltDrive_q;
  assign cycleActive = (state_q != cbi_pkg::stIdle);
  assign canStart = ownBus & ~extHalt & ~coreStopped;
  assign reqReady = ce & (state_q == cbi_pkg::stIdle) & canStart & ackSyncN & faultSyncN;

  always_comb
  begin
    state_d = state_q;
    req_d = req_q;
    pins_d = pins_q;
    rdata_d = rdata_q;
    done_d = 1'b0;
    fault_d = fault_q;
    rstCnt_d = rstCnt_q;
    level_d = level_q;
    init_d = init_q;
    haltDrive_d = haltDrive_q;
    if (!ce)
    begin
      done_d = done_q;
    end
    else
    begin
      level_d = ~iplSyncN;
      // Full initialisation needs reset and halt together from outside
      init_d = ~resetSyncN & ~haltSyncN & (rstCnt_q == `CBI_CNT_ZERO) & ~haltDrive_q;
      haltDrive_d = coreStopped;
      if (resetInstr && rstCnt_q == `CBI_CNT_ZERO)
        rstCnt_d = RESET_OUT_CYC + `CBI_SYNC_LAT;
      else if (rstCnt_q != `CBI_CNT_ZERO)
        rstCnt_d = rstCnt_q - `CBI_CNT_ONE;
      case (state_q)
        cbi_pkg::stIdle:
        begin
          pins_d.addrValidStrobeN = 1'b1;
          pins_d.upperByteStrobeN = 1'b1;
          pins_d.lowerByteStrobeN = 1'b1;
          pins_d.dataOe = 1'b0;
          // Lines float whenever another master owns the bus or we are halted
          pins_d.ctrlOe = canStart;
          pins_d.addrOe = canStart;
          if (reqValid && reqReady)
          begin
            req_d = req;
            fault_d = 1'b0;
            state_d = cbi_pkg::stAddr;
          end
        end
        cbi_pkg::stAddr:
        begin
          pins_d.addr = cycleAddr(req_q);
          pins_d.addrOe = 1'b1;
          pins_d.ctrlOe = 1'b1;
          pins_d.readNotWrite = req_q.rd | req_q.iack;
          state_d = cbi_pkg::stStrobe;
        end
        cbi_pkg::stStrobe:
        begin
          // Address has been stable for one cycle before the strobe
          pins_d.addrValidStrobeN = 1'b0;
          if (req_q.rd || req_q.iack)
          begin
            pins_d.upperByteStrobeN = ~(req_q.upper & ~req_q.iack);
            pins_d.lowerByteStrobeN = ~(req_q.lower | req_q.iack);
          end
          else
          begin
            pins_d.dataOut = laneData(req_q);
            pins_d.dataOe = 1'b1;
          end
          state_d = cbi_pkg::stAckWait;
        end
        cbi_pkg::stAckWait:
        begin
          // Write strobes follow data by one cycle so data is settled first
          pins_d.upperByteStrobeN = ~(req_q.upper & ~req_q.iack);
          pins_d.lowerByteStrobeN = ~(req_q.lower | req_q.iack);
          if (!faultSyncN)
          begin
            if (extHalt)
              state_d = cbi_pkg::stRetry;
            else
            begin
              fault_d = 1'b1;
              state_d = cbi_pkg::stClose;
            end
          end
          else if (!ackSyncN)
            state_d = cbi_pkg::stLatch;
        end
        cbi_pkg::stLatch:
        begin
          // Data passes the same synchroniser depth as the acknowledge
          if (req_q.rd || req_q.iack)
            rdata_d = dataSync;
          state_d = cbi_pkg::stClose;
        end
        cbi_pkg::stClose:
        begin
          pins_d.addrValidStrobeN = 1'b1;
          pins_d.upperByteStrobeN = 1'b1;
          pins_d.lowerByteStrobeN = 1'b1;
          pins_d.dataOe = 1'b0;
          done_d = 1'b1;
          state_d = cbi_pkg::stIdle;
        end
        cbi_pkg::stRetry:
        begin
          pins_d.addrValidStrobeN = 1'b1;
          pins_d.upperByteStrobeN = 1'b1;
          pins_d.lowerByteStrobeN = 1'b1;
          pins_d.dataOe = 1'b0;
          pins_d.addrOe = 1'b0;
          pins_d.ctrlOe = 1'b0;
          // Rerun only once halt and fault have both gone away
          if (!extHalt && faultSyncN && ownBus)
            state_d = cbi_pkg::stAddr;
        end
        default:
        begin
          state_d = cbi_pkg::stIdle;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state_q <= cbi_pkg::stIdle;
      req_q <= '0;
      pins_q <= '{addr: `CBI_ADDR_ZERO, addrOe: 1'b0, dataOut: `CBI_DATA_ZERO, dataOe: 1'b0,
                  addrValidStrobeN: 1'b1, readNotWrite: 1'b1, upperByteStrobeN: 1'b1,
                  lowerByteStrobeN: 1'b1, ctrlOe: 1'b0};
      rdata_q <= `CBI_DATA_ZERO;
      done_q <= 1'b0;
      fault_q <= 1'b0;
      rstCnt_q <= `CBI_CNT_ZERO;
      level_q <= `CBI_LEVEL_NONE;
      init_q <= 1'b0;
      haltDrive_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      req_q <= req_d;
      pins_q <= pins_d;
      rdata_q <= rdata_d;
      done_q <= done_d;
      fault_q <= fault_d;
      rstCnt_q <= rstCnt_d;
      level_q <= level_d;
      init_q <= init_d;
      haltDrive_q <= haltDrive_d;
    end
  end

  // =====================================================================
  // Outputs
  assign busPins = pins_q;
  assign respDone = done_q;
  assign respFault = fault_q;
  assign respData = rdata_q;
  assign interruptLevel = level_q;
  assign coreInit = init_q;
  assign extHalted = extHalt;
  assign resetPinOut = 1'b0;
  assign resetPinOe = (rstCnt_q > `CBI_SYNC_LAT);
  assign haltPinOut = 1'b0;
  assign haltPinOe = haltDrive_q;

endmodule : cbi_bus_ctrl

// [tb/cbi_bus_ctrl_asserts.sv]
`timescale 1ns/1ps

// ====
// Port checks of the bus controller
module cbi_bus_ctrl_asserts (
  // Clock and reset
  input logic clk_sys,
  input logic rst,
  // Core side
  input logic reqValid,
  input logic reqReady,
  input cbi_pkg::cbi_req_t req,
  input logic respDone,
  input logic resetInstr,
  // Pins
  input cbi_pkg::cbi_pins_t busPins,
  input logic transferAcknowledgeN,
  input logic busFaultInputN,
  input logic mastershipRequestN,
  input logic mastershipTakenN,
  input logic mastershipGrantN,
  input logic resetPinOe
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  logic take;
  logic [7:0] oeCnt_q;
  logic [7:0] oeCnt_d;
  assign take = reqValid && reqReady;
  // Length of the reset-out pulse, cleared whenever the pin is let go
  always_comb oeCnt_d = resetPinOe ? oeCnt_q + 8'h01 : 8'h00;
  always_ff @(posedge clk_sys) oeCnt_q <= rst ? 8'h00 : oeCnt_d;

  property p_addr_valid;
    !busPins.addrValidStrobeN |-> busPins.addrOe && busPins.ctrlOe;
  endproperty
  a_addr_valid: assert property (p_addr_valid)
    else $error("strobe low without address");
  property p_iack_addr;
    take && req.iack |-> ##2 busPins.addr == {20'hF_FFFF, $past(req.level, 2)};
  endproperty
  a_iack_addr: assert property (p_iack_addr)
    else $error("acknowledge address wrong");
  property p_dir;
    take |-> ##2 busPins.readNotWrite == ($past(req.rd, 2) || $past(req.iack, 2));
  endproperty
  a_dir: assert property (p_dir)
    else $error("direction wrong");
  property p_lanes;
    take && !req.iack |-> ##4 busPins.upperByteStrobeN == !$past(req.upper, 4)
      && busPins.lowerByteStrobeN == !$past(req.lower, 4);
  endproperty
  a_lanes: assert property (p_lanes)
    else $error("byte strobes wrong");
  property p_copy;
    !busPins.readNotWrite && busPins.dataOe && (busPins.upperByteStrobeN != busPins.lowerByteStrobeN)
      |-> busPins.dataOut[15:8] == busPins.dataOut[7:0];
  endproperty
  a_copy: assert property (p_copy)
    else $error("byte not copied");
  property p_close;
    respDone |-> busPins.addrValidStrobeN && busPins.upperByteStrobeN && busPins.lowerByteStrobeN;
  endproperty
  a_close: assert property (p_close)
    else $error("strobes still low at done");
  property p_ack;
    $fell(transferAcknowledgeN) && !busPins.addrValidStrobeN |-> ##[3:10] respDone;
  endproperty
  a_ack: assert property (p_ack)
    else $error("acknowledge not answered");
  property p_sync;
    respDone |-> !$past(transferAcknowledgeN, 3) || !$past(busFaultInputN, 3);
  endproperty
  a_sync: assert property (p_sync)
    else $error("done too soon after input");
  property p_grant;
    $fell(mastershipRequestN) && mastershipTakenN |-> ##[2:8] !mastershipGrantN;
  endproperty
  a_grant: assert property (p_grant)
    else $error("grant missing");
  property p_rst_out;
    $fell(resetPinOe) |-> oeCnt_q == 8'h7C;
  endproperty
  a_rst_out: assert property (p_rst_out)
    else $error("reset pulse length wrong");
  c_read: cover property (take && req.rd);
  c_fault: cover property (!busFaultInputN && !busPins.addrValidStrobeN);
  c_grant: cover property (!mastershipGrantN);
  c_reset: cover property (resetInstr);
endmodule : cbi_bus_ctrl_asserts

bind cbi_bus_ctrl cbi_bus_ctrl_asserts i_chk (.clk_sys, .rst, .reqValid, .reqReady, .req, .respDone,
  .resetInstr, .busPins, .transferAcknowledgeN, .busFaultInputN, .mastershipRequestN,
  .mastershipTakenN, .mastershipGrantN, .resetPinOe);

// [tb/cbi_mem_model.sv]
`timescale 1ns/1ps

// ====
// Responder: word memory, vector source, optional fault
module cbi_mem_model (
  // Clock
  input logic clk_sys,
  // Bus
  input cbi_pkg::cbi_pins_t busPins,
  output logic [15:0] dataIn,
  output logic transferAcknowledgeN,
  output logic busFaultInputN,
  // Scenario control
  input logic [3:0] waitCyc,
  input logic faultMode,
  input logic [7:0] vector
);
  logic [15:0] mem [256];
  logic [3:0] cnt;
  logic iack;
  logic [7:0] ix;
  assign iack = busPins.addr[22:3] == 20'hF_FFFF;
  assign ix = busPins.addr[7:0];
  initial
  begin
    dataIn = 16'hA5A5;
    transferAcknowledgeN = 1'b1;
    busFaultInputN = 1'b1;
    cnt = 4'h0;
  end
  always @(posedge clk_sys)
  begin
    if (busPins.addrValidStrobeN)
    begin
      // Released lines flip so a stale word never reads as fresh
      if (!transferAcknowledgeN || !busFaultInputN) dataIn <= ~dataIn;
      transferAcknowledgeN <= 1'b1;
      busFaultInputN <= 1'b1;
      cnt <= 4'h0;
    end
    else
    begin
      // Only the selected lane is stored; the copied lane is ignored
      if (!busPins.readNotWrite && !busPins.upperByteStrobeN) mem[ix][15:8] <= busPins.dataOut[15:8];
      if (!busPins.readNotWrite && !busPins.lowerByteStrobeN) mem[ix][7:0] <= busPins.dataOut[7:0];
      if (cnt != waitCyc) cnt <= cnt + 4'h1;
      else if (faultMode) busFaultInputN <= 1'b0;
      else
      begin
        dataIn <= iack ? {~vector, vector} : mem[ix];
        transferAcknowledgeN <= 1'b0;
      end
    end
  end
endmodule : cbi_mem_model

// [tb/tb_top.sv]
`timescale 1ns/1ps

module tb_top;
  typedef struct packed {logic [15:0] exp; logic [15:0] msk; logic flt;} cbi_note_t;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic reqValid = 1'b0;
  logic resetInstr = 1'b0;
  logic coreStopped = 1'b0;
  logic mastershipRequestN = 1'b1;
  logic mastershipTakenN = 1'b1;
  logic extRst = 1'b0;
  logic extHalt = 1'b0;
  logic faultMode = 1'b0;
  logic [3:0] waitCyc = 4'h0;
  logic [7:0] vector = 8'h00;
  logic [2:0] ipl = 3'h0;
  cbi_pkg::cbi_req_t req = '0;
  cbi_pkg::cbi_pins_t busPins;
  logic reqReady, respDone, respFault, coreInit, extHalted, mastershipGrantN;
  logic transferAcknowledgeN, busFaultInputN, resetPinOe, haltPinOe;
  logic [15:0] respData, dataIn, w, b, m;
  logic [2:0] interruptLevel;
  logic [22:0] a;
  logic [1:0] rl;
  cbi_note_t notes[$];
  cbi_note_t cur;
  int n_errors = 0;
  int checks = 0;
  int i, k;

  always #25 clk_sys = ~clk_sys;

  cbi_bus_ctrl i_dut (.clk_sys, .rst, .ce, .reqValid, .reqReady, .req, .respDone, .respFault,
    .respData, .resetInstr, .coreStopped, .coreInit, .extHalted, .interruptLevel, .busPins, .dataIn,
    .transferAcknowledgeN, .busFaultInputN, .mastershipRequestN, .mastershipGrantN, .mastershipTakenN,
    .interruptLevelBitLowN(~ipl[0]), .interruptLevelBitMidN(~ipl[1]), .interruptLevelBitHighN(~ipl[2]),
    .resetPinIn(!(resetPinOe || extRst)), .resetPinOut(), .resetPinOe,
    .haltPinIn(!(haltPinOe || extHalt)), .haltPinOut(), .haltPinOe);
  cbi_mem_model i_mem (.clk_sys, .busPins, .dataIn, .transferAcknowledgeN, .busFaultInputN,
    .waitCyc, .faultMode, .vector);

  // ====
  // Checking
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task summarize;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : summarize

  task automatic tmo(input string nm);
    n_errors++;
    $display("FAIL %s expected done seen timeout", nm);
    summarize();
  endtask : tmo

  always @(negedge clk_sys)
  begin
    if (respDone === 1'b1)
    begin
      if (notes.size() == 0) chk("spare done", 16'h0000, 16'h0001);
      else
      begin
        cur = notes.pop_front();
        chk("fault", 16'(cur.flt), 16'(respFault));
        if (!cur.flt) chk("data", cur.exp, respData & cur.msk);
      end
    end
  end

  // ====
  // Core request driver
  task automatic xfer(input cbi_pkg::cbi_req_t r, input logic [15:0] e, input logic [15:0] mk);
    int t;
    @(negedge clk_sys);
    req = r;
    reqValid = 1'b1;
    notes.push_back('{e & mk, mk, faultMode});
    for (t = 0; t < 300 && reqReady !== 1'b1; t++) @(negedge clk_sys);
    @(negedge clk_sys);
    reqValid = 1'b0;
    for (t = t; t < 300 && respDone !== 1'b1; t++) @(negedge clk_sys);
    if (t >= 300) tmo("transfer");
  endtask : xfer

  // ====
  // Scenarios
  initial
  begin
    k = $urandom(32'h0000_7ded);
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    extRst = 1'b1;
    extHalt = 1'b1;
    repeat (6) @(negedge clk_sys);
    chk("init", 16'h0001, 16'(coreInit));
    extRst = 1'b0;
    extHalt = 1'b0;
    repeat (6) @(negedge clk_sys);
    for (i = 0; i < 24; i++)
    begin
      a = {1'b0, 22'($urandom)};
      w = 16'($urandom);
      b = 16'($urandom);
      rl = 2'($urandom_range(1, 3));
      m = {{8{rl[1]}}, {8{rl[0]}}};
      waitCyc = 4'($urandom_range(0, 6));
      xfer('{1'b0, 1'b0, 1'b1, 1'b1, a, 3'h0, w}, 16'h0000, 16'h0000);
      xfer('{1'b0, 1'b0, i[0], !i[0], a, 3'h0, b}, 16'h0000, 16'h0000);
      if (i[0]) w[15:8] = b[15:8];
      else w[7:0] = b[7:0];
      xfer('{1'b0, 1'b1, rl[1], rl[0], a, 3'h0, 16'h0000}, w, m);
    end
    mastershipRequestN = 1'b0;
    for (k = 0; k < 20 && mastershipGrantN !== 1'b0; k++) @(negedge clk_sys);
    chk("grant", 16'h0000, 16'(mastershipGrantN));
    mastershipTakenN = 1'b0;
    mastershipRequestN = 1'b1;
    repeat (6) @(negedge clk_sys);
    chk("ready taken", 16'h0000, 16'(reqReady));
    mastershipTakenN = 1'b1;
    repeat (6) @(negedge clk_sys);
    for (i = 1; i < 8; i++)
    begin
      vector = 8'($urandom);
      xfer('{1'b1, 1'b1, 1'b0, 1'b1, 23'h00_0000, 3'(i), 16'h0000}, {8'h00, vector}, 16'h00FF);
    end
    faultMode = 1'b1;
    xfer('{1'b0, 1'b1, 1'b1, 1'b1, a, 3'h0, 16'h0000}, 16'h0000, 16'h0000);
    faultMode = 1'b0;
    xfer('{1'b0, 1'b0, 1'b1, 1'b1, a, 3'h0, w}, 16'h0000, 16'h0000);
    // Fault under external halt floats the bus and reruns the read once both go away
    waitCyc = 4'h3;
    fork
      xfer('{1'b0, 1'b1, 1'b1, 1'b1, a, 3'h0, 16'h0000}, w, 16'hFFFF);
      begin
        for (k = 0; k < 40 && busPins.addrValidStrobeN !== 1'b0; k++) @(negedge clk_sys);
        extHalt = 1'b1;
        faultMode = 1'b1;
        for (k = 0; k < 40 && busPins.addrValidStrobeN !== 1'b1; k++) @(negedge clk_sys);
        chk("retry float", 16'h0000, 16'({busPins.addrOe, busPins.ctrlOe}));
        chk("halted", 16'h0001, 16'(extHalted));
        faultMode = 1'b0;
        repeat (8) @(negedge clk_sys);
        extHalt = 1'b0;
      end
    join
    for (i = 0; i < 8; i++)
    begin
      ipl = 3'(i);
      repeat (6) @(negedge clk_sys);
      chk("level", 16'(i), 16'(interruptLevel));
    end
    ce = 1'b0;
    ipl = 3'h2;
    repeat (6) @(negedge clk_sys);
    chk("frozen level", 16'h0007, 16'(interruptLevel));
    chk("frozen ready", 16'h0000, 16'(reqReady));
    ce = 1'b1;
    resetInstr = 1'b1;
    extHalt = 1'b1;
    @(negedge clk_sys);
    resetInstr = 1'b0;
    for (k = 0; k < 10 && resetPinOe !== 1'b1; k++) @(negedge clk_sys);
    repeat (6) @(negedge clk_sys);
    chk("own reset init", 16'h0000, 16'(coreInit));
    for (k = 6; k < 300 && resetPinOe === 1'b1; k++) @(negedge clk_sys);
    chk("reset pulse", 16'h007C, 16'(k));
    repeat (3) @(negedge clk_sys);
    chk("own reset tail", 16'h0000, 16'(coreInit));
    extHalt = 1'b0;
    coreStopped = 1'b1;
    repeat (6) @(negedge clk_sys);
    chk("halt drive", 16'h0001, 16'(haltPinOe));
    chk("ready stopped", 16'h0000, 16'(reqReady));
    summarize();
  end
endmodule : tb_top
